// ### core/fppio_top.sv
// parallel i/o block: three bidirectional 8-bit ports and one input-only port
// assumes: avalon-mm master on ref_clk, pins asynchronous, pads resolve oe_n
//
// Summary of operation
// - thirty-two port lines, four ports of eight bits each.
// - ports a, b, c drive when direction bit is one, else input.
// - value registers at 0000-0002, direction registers at 0004-0006.
// - any reset clears direction registers; data latches keep their value.
// - direction registers are readable and writable by software.
// - writing data with direction zero updates latch only, pin stays undriven.
// - reading a bit with direction zero returns the pin level.
// - reading a bit with direction one returns the output latch.
// - port d is eight bits, input only, pins shared with serial units.
// - during reset all peripheral drivers on port d are disabled.
//
// Our own choice: register access over Avalon-MM.
`timescale 1ns/100ps
`include "fppio_regs.svh"

module fppio_top (
    input wire logic ref_clk,
    input wire logic rst,
    // avalon-mm slave
    input wire logic [`FPPIO_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [`FPPIO_DATA_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [`FPPIO_DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    // port a
    input wire logic [`FPPIO_PORT_W-1:0] port_a_in,
    output logic [`FPPIO_PORT_W-1:0] port_a_out,
    output logic [`FPPIO_PORT_W-1:0] port_a_oe_n,
    // port b
    input wire logic [`FPPIO_PORT_W-1:0] port_b_in,
    output logic [`FPPIO_PORT_W-1:0] port_b_out,
    output logic [`FPPIO_PORT_W-1:0] port_b_oe_n,
    // port c
    input wire logic [`FPPIO_PORT_W-1:0] port_c_in,
    output logic [`FPPIO_PORT_W-1:0] port_c_out,
    output logic [`FPPIO_PORT_W-1:0] port_c_oe_n,
    // port d, input only as a port; serial units may drive shared pins
    input wire logic [`FPPIO_PORT_W-1:0] port_d_in,
    input wire logic [`FPPIO_PORT_W-1:0] periph_d_out,
    input wire logic [`FPPIO_PORT_W-1:0] periph_d_drive,
    output logic [`FPPIO_PORT_W-1:0] port_d_out,
    output logic [`FPPIO_PORT_W-1:0] port_d_oe_n
);

    // ****************************************************************
    // declarations
    // ****************************************************************
    fppio_pkg::fppio_state_t st;
    fppio_pkg::fppio_state_t next_st;

    logic [`FPPIO_NPINS-1:0] pin_raw;
    logic [`FPPIO_NPINS-1:0] pin_sync;
    logic [`FPPIO_NBIDIR-1:0][`FPPIO_PORT_W-1:0] bidir_pin;
    logic [`FPPIO_NBIDIR-1:0][`FPPIO_PORT_W-1:0] bidir_view;
    logic [`FPPIO_NBIDIR-1:0][`FPPIO_PORT_W-1:0] pin_out;
    logic [`FPPIO_NBIDIR-1:0][`FPPIO_PORT_W-1:0] pin_oe_n;
    logic [`FPPIO_PORT_W-1:0] port_d_pin;
    logic [`FPPIO_IDX_W-1:0] reg_idx;
    logic aligned;
    logic req;
    logic first_cycle;
    logic wr_take;
    logic lane0;

    // ****************************************************************
    // pin sampling: four ports of eight lines
    // ****************************************************************
    // every sampled line passes two flops before the read mux sees it
    assign pin_raw = {port_d_in, port_c_in, port_b_in, port_a_in};

    fppio_sync u_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .pin_raw(pin_raw),
        .pin_sync(pin_sync)
    );

    assign bidir_pin[0] = pin_sync[7:0];
    assign bidir_pin[1] = pin_sync[15:8];
    assign bidir_pin[2] = pin_sync[23:16];
    assign port_d_pin = pin_sync[31:24];

    // ****************************************************************
    // per-port pin drive and read view
    // ****************************************************************
    genvar gp;
    generate
        for (gp = 0; gp < `FPPIO_NBIDIR; gp = gp + 1) begin : g_port
            // latch always on the pad output; direction gates the driver
            assign pin_out[gp] = st.latch[gp];
            assign pin_oe_n[gp] = ~st.dir[gp];
            // output bits read back the latch, not the pad
            assign bidir_view[gp] = (st.latch[gp] & st.dir[gp])
                | (bidir_pin[gp] & ~st.dir[gp]);
        end
    endgenerate

    assign port_a_out = pin_out[0];
    assign port_b_out = pin_out[1];
    assign port_c_out = pin_out[2];
    assign port_a_oe_n = pin_oe_n[0];
    assign port_b_oe_n = pin_oe_n[1];
    assign port_c_oe_n = pin_oe_n[2];

    // ****************************************************************
    // port d shared drivers
    // ****************************************************************
    // reset overrides the serial units directly, no clock needed
    assign port_d_out = rst ? `FPPIO_ZERO8 : periph_d_out;
    assign port_d_oe_n = rst ? `FPPIO_ONES8 : ~periph_d_drive;

    // ****************************************************************
    // bus decode
    // ****************************************************************
    assign reg_idx = avs_address[`FPPIO_IDX_MSB:`FPPIO_IDX_LSB];
    assign aligned = (avs_address[`FPPIO_ALIGN_MSB:0] == `FPPIO_ALIGNED);
    assign req = avs_read | avs_write;
    // one wait state lets read data come from a flop
    assign first_cycle = req & ~st.ack;
    assign wr_take = avs_write & st.ack & aligned;
    assign lane0 = avs_byteenable[0];

    assign avs_waitrequest = first_cycle;
    assign avs_readdata = st.rdata;

    // ****************************************************************
    // read mux
    // ****************************************************************
    function automatic logic [`FPPIO_PORT_W-1:0] fppio_read_byte(
        input logic [`FPPIO_IDX_W-1:0] idx,
        input logic [`FPPIO_NBIDIR-1:0][`FPPIO_PORT_W-1:0] view,
        input logic [`FPPIO_NBIDIR-1:0][`FPPIO_PORT_W-1:0] dir,
        input logic [`FPPIO_PORT_W-1:0] dpin
    );
        logic [`FPPIO_PORT_W-1:0] res;
        res = `FPPIO_ZERO8;
        unique case (idx)
            `FPPIO_IDX_A_VALUE: res = view[0];
            `FPPIO_IDX_B_VALUE: res = view[1];
            `FPPIO_IDX_C_VALUE: res = view[2];
            `FPPIO_IDX_D_VALUE: res = dpin;
            `FPPIO_IDX_A_DIR: res = dir[0];
            `FPPIO_IDX_B_DIR: res = dir[1];
            `FPPIO_IDX_C_DIR: res = dir[2];
            default: res = `FPPIO_ZERO8;
        endcase
        return res;
    endfunction

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        next_st = st;
        // ack rises for exactly one cycle per request
        next_st.ack = first_cycle;
        if (first_cycle & avs_read) begin
            next_st.rdata = {24'h000000, `FPPIO_ZERO8};
            if (aligned) begin
                next_st.rdata = {24'h000000,
                    fppio_read_byte(reg_idx, bidir_view, st.dir, port_d_pin)};
            end
        end
        // writes land on the edge that ends the access
        if (wr_take & lane0) begin
            unique case (reg_idx)
                `FPPIO_IDX_A_VALUE: next_st.latch[0] = avs_writedata[7:0];
                `FPPIO_IDX_B_VALUE: next_st.latch[1] = avs_writedata[7:0];
                `FPPIO_IDX_C_VALUE: next_st.latch[2] = avs_writedata[7:0];
                // glitch-free turn-on is up to software ordering
                `FPPIO_IDX_A_DIR: next_st.dir[0] = avs_writedata[7:0];
                `FPPIO_IDX_B_DIR: next_st.dir[1] = avs_writedata[7:0];
                `FPPIO_IDX_C_DIR: next_st.dir[2] = avs_writedata[7:0];
                default: next_st = next_st;
            endcase
        end
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    // latches get no reset value: they hold across any reset
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st.dir[0] <= `FPPIO_DIR_RESET;
            st.dir[1] <= `FPPIO_DIR_RESET;
            st.dir[2] <= `FPPIO_DIR_RESET;
            st.ack <= 1'b0;
            st.rdata <= `FPPIO_RDATA_RESET;
        end else begin
            st <= next_st;
        end
    end

endmodule

// ### core/fppio_regs.svh
// register offsets, field widths and reset values of the parallel port block
// assumes: included by the package and the design modules by bare name
`ifndef FPPIO_REGS_SVH
`define FPPIO_REGS_SVH

// ****************************************************************
// geometry
// ****************************************************************
`define FPPIO_PORT_W 8
`define FPPIO_NBIDIR 3
`define FPPIO_NPINS 32
`define FPPIO_ADDR_W 5
`define FPPIO_DATA_W 32
`define FPPIO_IDX_W 3

// ****************************************************************
// register indices; byte address is four times the index
// ****************************************************************
`define FPPIO_IDX_A_VALUE 3'h0
`define FPPIO_IDX_B_VALUE 3'h1
`define FPPIO_IDX_C_VALUE 3'h2
`define FPPIO_IDX_D_VALUE 3'h3
`define FPPIO_IDX_A_DIR 3'h4
`define FPPIO_IDX_B_DIR 3'h5
`define FPPIO_IDX_C_DIR 3'h6

// ****************************************************************
// field positions inside the bus address
// ****************************************************************
`define FPPIO_IDX_LSB 2
`define FPPIO_IDX_MSB 4
`define FPPIO_ALIGN_MSB 1
`define FPPIO_ALIGNED 2'h0

// ****************************************************************
// reset values
// ****************************************************************
`define FPPIO_DIR_RESET 8'h00
`define FPPIO_RDATA_RESET 32'h00000000
`define FPPIO_SYNC_RESET 32'h00000000
`define FPPIO_ZERO8 8'h00
`define FPPIO_ONES8 8'hFF

`endif

// ### core/fppio_pkg.sv
// types shared by the parallel port block
// assumes: fppio_regs.svh is on the include path
`include "fppio_regs.svh"

package fppio_pkg;

    // ****************************************************************
    // state of the register slave
    // ****************************************************************
    typedef struct packed {
        logic [`FPPIO_NBIDIR-1:0][`FPPIO_PORT_W-1:0] latch;
        logic [`FPPIO_NBIDIR-1:0][`FPPIO_PORT_W-1:0] dir;
        logic ack;
        logic [`FPPIO_DATA_W-1:0] rdata;
    } fppio_state_t;

    // ****************************************************************
    // state of the pin synchroniser
    // ****************************************************************
    typedef struct packed {
        logic [`FPPIO_NPINS-1:0] stage1;
        logic [`FPPIO_NPINS-1:0] stage2;
    } fppio_sync_state_t;

endpackage

// ### core/fppio_sync.sv
// two-flop synchroniser for all sampled port pins
// assumes: pins are asynchronous to ref_clk; stage1 is read by stage2 only
`timescale 1ns/100ps
`include "fppio_regs.svh"

module fppio_sync (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [`FPPIO_NPINS-1:0] pin_raw,
    output logic [`FPPIO_NPINS-1:0] pin_sync
);

    fppio_pkg::fppio_sync_state_t st;
    fppio_pkg::fppio_sync_state_t next_st;

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        next_st = st;
        next_st.stage1 = pin_raw;
        next_st.stage2 = st.stage1;
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st.stage1 <= `FPPIO_SYNC_RESET;
            st.stage2 <= `FPPIO_SYNC_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign pin_sync = st.stage2;

endmodule

// ### verif/fppio_monitor.sv
// checker for the parallel port block: bus timing, direction and port d gating
// assumes: bound to fppio_top, sees its ports only
`timescale 1ns/100ps
module fppio_monitor (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [7:0] port_a_out,
    input wire logic [7:0] port_a_oe_n,
    input wire logic [7:0] port_b_oe_n,
    input wire logic [7:0] port_c_oe_n,
    input wire logic [7:0] periph_d_out,
    input wire logic [7:0] periph_d_drive,
    input wire logic [7:0] port_d_out,
    input wire logic [7:0] port_d_oe_n
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    wire logic wr_done = avs_write & ~avs_waitrequest & avs_byteenable[0];
    chk_first_wait: assert property (
        (avs_read | avs_write) && $past(~(avs_read | avs_write) | ~avs_waitrequest) |-> avs_waitrequest)
        else $error("fresh request got no wait state");
    chk_one_wait: assert property (avs_waitrequest |=> !avs_waitrequest)
        else $error("more than one wait state");
    chk_value_out: assert property (
        wr_done && avs_address == 5'h00 |=> port_a_out == $past(avs_writedata[7:0]))
        else $error("port a latch not updated");
    chk_dir_drive: assert property (
        wr_done && avs_address == 5'h10 |=> port_a_oe_n == ~$past(avs_writedata[7:0]))
        else $error("port a drive does not follow direction");
    chk_dir_reset: assert property (@(posedge ref_clk) disable iff (1'b0)
        rst |-> (port_a_oe_n & port_b_oe_n & port_c_oe_n) == 8'hFF)
        else $error("pin driven during reset");
    chk_portd_reset: assert property (@(posedge ref_clk) disable iff (1'b0)
        rst |-> port_d_oe_n == 8'hFF && port_d_out == 8'h00)
        else $error("port d driver active in reset");
    chk_portd_pass: assert property (
        port_d_oe_n == ~periph_d_drive && port_d_out == periph_d_out)
        else $error("port d drive not from serial units");
    chk_upper_zero: assert property (
        avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    chk_unmapped_zero: assert property (
        avs_read && !avs_waitrequest && avs_address == 5'h1C |-> avs_readdata == 32'h00000000)
        else $error("unmapped read not zero");
endmodule
bind fppio_top fppio_monitor i_mon (.ref_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .port_a_out, .port_a_oe_n, .port_b_oe_n,
    .port_c_oe_n, .periph_d_out, .periph_d_drive, .port_d_out, .port_d_oe_n);

// ### verif/fppio_pads.sv
// pad model: resolves each bidirectional pin from block and external drivers
// assumes: no pull on the pins; the bench drives ext_val and ext_en
`timescale 1ns/100ps
module fppio_pads (
    input wire logic ref_clk,
    input wire logic [2:0][7:0] dut_out,
    input wire logic [2:0][7:0] dut_oe_n,
    input wire logic [2:0][7:0] ext_val,
    input wire logic [2:0][7:0] ext_en,
    output logic [2:0][7:0] pin
);
    // floating lines wander so a stale value cannot pass for a read
    logic [7:0] drift = 8'hA5;
    always @(posedge ref_clk) drift <= ~drift;
    always_comb begin
        for (int p = 0; p < 3; p++) begin
            pin[p] = (~dut_oe_n[p] & dut_out[p]) | (dut_oe_n[p] & ext_en[p] & ext_val[p])
                | (dut_oe_n[p] & ~ext_en[p] & drift);
        end
    end
endmodule

// ### verif/tb_top.sv
// register-level bench of the parallel port block
// assumes: fppio_top, fppio_pads and the bound checker are compiled first
`timescale 1ns/100ps
module tb_top;
    logic ref_clk = 1'b0;
    logic rst = 1'b0;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [2:0][7:0] pin;
    // one port per byte drives these, so they are nets
    wire [2:0][7:0] pout;
    wire [2:0][7:0] poe_n;
    logic [2:0][7:0] ext_val = 24'h000000;
    logic [2:0][7:0] ext_en = 24'h000000;
    logic [7:0] pd_in = 8'h00, periph_out = 8'h00, periph_drv = 8'h00, pd_out, pd_oe_n;
    int n_errors = 0;
    int cmp_count = 0;
    initial begin
        forever #20 ref_clk = ~ref_clk;
    end
    fppio_top i_dut (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .port_a_in(pin[0]), .port_a_out(pout[0]), .port_a_oe_n(poe_n[0]),
        .port_b_in(pin[1]), .port_b_out(pout[1]), .port_b_oe_n(poe_n[1]),
        .port_c_in(pin[2]), .port_c_out(pout[2]), .port_c_oe_n(poe_n[2]), .port_d_in(pd_in),
        .periph_d_out(periph_out), .periph_d_drive(periph_drv), .port_d_out(pd_out), .port_d_oe_n(pd_oe_n));
    fppio_pads i_pads (.ref_clk(ref_clk), .dut_out(pout), .dut_oe_n(poe_n), .ext_val(ext_val),
        .ext_en(ext_en), .pin(pin));
    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic tally_and_finish;
        $display("mismatches %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // request stays up on return, so calls run back to back
    task automatic acc(input logic wr, input logic [4:0] a, input logic [7:0] d, input logic [7:0] exp);
        int i;
        avs_address <= a;
        avs_writedata <= {24'h000000, d};
        avs_write <= wr;
        avs_read <= ~wr;
        for (i = 0; i < 16; i++) begin
            @(posedge ref_clk);
            if (avs_waitrequest === 1'b0) break;
        end
        if (i == 16) begin
            n_errors++;
            tally_and_finish;
        end else if (!wr) begin
            chk(avs_readdata[7:0], exp);
        end
    endtask
    task automatic rel;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge ref_clk);
    endtask
    initial begin
        // a real edge on rst, so the async reset acts before the first clock
        rst <= 1'b1;
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        for (int p = 0; p < 3; p++) acc(0, 5'(16 + 4 * p), 8'h00, 8'h00);
        acc(0, 5'h1C, 8'h00, 8'h00);
        acc(0, 5'h01, 8'h00, 8'h00);
        pd_in <= 8'h96;
        acc(1, 5'h0C, 8'hFF, 8'h00);
        acc(0, 5'h0C, 8'h00, 8'h96);
        $display("test reset state done");
        for (int p = 0; p < 3; p++) begin
            ext_val[p] <= 8'h3C;
            ext_en[p] <= 8'hFF;
            acc(1, 5'(4 * p), 8'hC3, 8'h00);
            acc(0, 5'(4 * p), 8'h00, 8'h3C);
            chk(poe_n[p], 8'hFF);
            chk(pout[p], 8'hC3);
            ext_en[p] <= 8'hF0;
            acc(1, 5'(16 + 4 * p), 8'h0F, 8'h00);
            acc(0, 5'(16 + 4 * p), 8'h00, 8'h0F);
            chk(poe_n[p], 8'hF0);
            acc(0, 5'(4 * p), 8'h00, 8'h33);
            acc(1, 5'(4 * p), 8'h5A, 8'h00);
            acc(0, 5'(4 * p), 8'h00, 8'h3A);
            chk(pin[p], 8'h3A);
        end
        $display("test port direction done");
        periph_out <= 8'h05;
        periph_drv <= 8'h0F;
        rel;
        @(posedge ref_clk);
        chk(pd_oe_n, 8'hF0);
        chk(pd_out, 8'h05);
        rst <= 1'b1;
        @(posedge ref_clk);
        chk(pd_oe_n, 8'hFF);
        chk(pd_out, 8'h00);
        rst <= 1'b0;
        @(posedge ref_clk);
        for (int p = 0; p < 3; p++) begin
            chk(poe_n[p], 8'hFF);
            chk(pout[p], 8'h5A);
            acc(0, 5'(16 + 4 * p), 8'h00, 8'h00);
        end
        rel;
        $display("test reset in mid-run done");
        tally_and_finish;
    end
endmodule
